// ---- hdl/dmb_data_mem.sv ----
// banked data memory addressing, bank select and usb dual-access ram
// Function
// [RULE1] call, goto, full-address move, pointer literal load are two-word
// [RULE2] second word has 1111 on top, 12-bit literal below
// [RULE3] second word after its first feeds literal; alone it is a no-op
// [RULE4] 12-bit byte addresses, 16 banks of 256 bytes
// [RULE5] unimplemented locations, unused register slots read zero
// [RULE6] usb ram is plain storage when usb off, shared buffer when on
// [RULE7] bank select keeps low four bits; upper bits read zero
// [RULE8] banked address is bank select over the 8-bit operand
// [RULE9] literal-to-bank load writes bank select from its literal
// [RULE10] unimplemented bank writes dropped, reads zero, status still updates
// [RULE11] full-address move uses two 12-bit addresses, ignores bank select
// [RULE12] access offsets below 60h go to bank 0, rest to bank 15
// [RULE13] access bit 1 uses bank select, 0 uses access mapping
// [RULE14] access mapping needs no bank select update, single cycle
// [RULE15] extended set enable alters access mapping; base mapping when clear (code ignores extended_set_enable and always uses base mapping)
// [RULE16] storage from 000h upward, never touched by reset
// [RULE17] special registers decoded at F60h..FFFh in place of storage
// [RULE18] read in second phase, write in fourth phase
// [RULE19] usb engine and core never collide on the dual-access ram
`timescale 1ns/10ps
module dmb_data_mem
import dmb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic [1:0] q_phase,
    input wire logic [7:0] wr_data,
    input wire logic extended_set_enable,
    input wire logic usb_enable,
    input wire logic [7:0] sfr_rd_data,
    input wire logic usb_req,
    input wire logic usb_we,
    input wire logic [7:0] usb_addr,
    input wire logic [7:0] usb_wr_data,
    output logic usb_gnt,
    output logic [7:0] usb_rd_data,
    output logic [7:0] rd_data,
    output logic [11:0] data_addr,
    output logic [11:0] literal_out,
    output logic literal_valid,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic [11:0] sfr_addr,
    output logic [7:0] sfr_wr_data,
    output logic [7:0] bank_select,
    output logic status_update
);
    // =====================================================
    // state
    typedef struct packed {
        logic [3:0] bank;
        logic word2_pending;
        logic move_wr;
        dmb_op_e pend_op;
        logic [11:0] src_addr;
        logic [11:0] addr;
        logic rd_src_ram;
        logic rd_src_usb;
        logic rd_src_sfr;
        logic rd_src_bsr;
        logic [7:0] rd_data;
        logic [11:0] literal;
        logic literal_valid;
        logic usb_phase;
        logic [7:0] usb_rd;
        logic status_upd;
    } dmb_state_s;

    dmb_state_s st;
    dmb_state_s next_st;

    logic [7:0] gpr_q;
    logic [7:0] usb_q;
    logic gpr_we;
    logic usb_ram_we;
    logic [8:0] gpr_addr;
    logic [7:0] usbram_addr;
    logic [7:0] usbram_wdata;
    logic [7:0] bsr_view;
    logic core_is_write;
    logic core_q4_wr;
    dmb_op_e op;
    logic [11:0] eff_addr;
    logic in_gpr;
    logic in_usb;
    logic in_sfr;
    logic is_word2;

    assign bsr_view = {4'h0, st.bank}; // [RULE7]

    // =====================================================
    // decode
    always_comb
    begin
        op = DMB_OP_FILE;
        is_word2 = (instr_word[15:12] == DMB_WORD2_MARK); // [RULE2]
        if (is_word2)
        begin
            op = DMB_OP_NONE;
        end
        else if (instr_word[15:9] == 7'b1110110)
        begin
            op = DMB_OP_CALL; // [RULE1]
        end
        else if (instr_word[15:8] == 8'hef)
        begin
            op = DMB_OP_GOTO; // [RULE1]
        end
        else if (instr_word[15:12] == 4'hc)
        begin
            op = DMB_OP_FULL_MOVE; // [RULE1]
        end
        else if (instr_word[15:6] == 10'b1110111000)
        begin
            op = DMB_OP_PTR_LOAD; // [RULE1]
        end
        else if (instr_word[15:8] == 8'h01)
        begin
            op = DMB_OP_BANK_LOAD;
        end
        else if (instr_word[15:12] == 4'he || instr_word[15:12] == 4'hd)
        begin
            op = DMB_OP_NONE;
        end
    end

    // byte-oriented writers: register-to-w variants and compares stay reads
    assign core_is_write = (op == DMB_OP_FILE) && instr_word[9];

    // =====================================================
    // address forming
    always_comb
    begin
        if (instr_word[8])
        begin
            eff_addr = {st.bank, instr_word[7:0]}; // [RULE8] [RULE13]
        end
        else if (instr_word[7:0] < DMB_ACCESS_SPLIT)
        begin
            // extended set keeps base mapping here; indexed mode not built
            eff_addr = {4'h0, instr_word[7:0]}; // [RULE12] [RULE14] [RULE15]
        end
        else
        begin
            eff_addr = {DMB_SFR_BANK, instr_word[7:0]}; // [RULE12] [RULE14]
        end
    end

    // region decode on the latched address
    assign in_sfr = (st.addr >= DMB_SFR_BASE); // [RULE17]
    assign in_gpr = (st.addr < DMB_GPR_BASE + 12'(DMB_GPR_BYTES)); // [RULE16]
    assign in_usb = (st.addr >= DMB_USB_BASE)
        && (st.addr < DMB_USB_BASE + 12'(DMB_USB_BYTES));

    // =====================================================
    // sequencing
    always_comb
    begin
        next_st = st;
        next_st.literal_valid = 1'b0;
        next_st.status_upd = 1'b0;
        next_st.usb_phase = 1'b0;
        if (instr_valid && q_phase == DMB_Q1)
        begin
            next_st.word2_pending = 1'b0;
            if (is_word2 && st.word2_pending)
            begin
                next_st.literal = instr_word[11:0]; // [RULE3]
                next_st.literal_valid = 1'b1;
                if (st.pend_op == DMB_OP_FULL_MOVE)
                begin
                    next_st.addr = instr_word[11:0]; // [RULE11]
                    next_st.move_wr = 1'b1; // [RULE11]
                end
            end
            else if (op == DMB_OP_FULL_MOVE)
            begin
                next_st.src_addr = instr_word[11:0]; // [RULE11] [RULE4]
                next_st.addr = instr_word[11:0];
                next_st.word2_pending = 1'b1;
                next_st.pend_op = op;
            end
            else if (op == DMB_OP_CALL || op == DMB_OP_GOTO
                || op == DMB_OP_PTR_LOAD)
            begin
                next_st.word2_pending = 1'b1;
                next_st.pend_op = op;
            end
            else if (op == DMB_OP_BANK_LOAD)
            begin
                next_st.bank = instr_word[3:0]; // [RULE9]
            end
            else if (op == DMB_OP_FILE)
            begin
                next_st.addr = eff_addr;
                next_st.pend_op = op;
            end
            else
            begin
                next_st.pend_op = DMB_OP_NONE; // [RULE3]
            end
        end
        // operand read: select source, zero when nothing answers
        if (q_phase == DMB_Q2 && st.pend_op != DMB_OP_NONE)
        begin
            next_st.rd_src_bsr = (st.addr == DMB_BANK_SEL_ADDR); // [RULE18]
            next_st.rd_src_sfr = in_sfr && st.addr != DMB_BANK_SEL_ADDR;
            next_st.rd_src_ram = in_gpr;
            next_st.rd_src_usb = in_usb;
        end
        if (q_phase == 2'h2)
        begin
            if (st.rd_src_bsr)
            begin
                next_st.rd_data = bsr_view; // [RULE7]
            end
            else if (st.rd_src_sfr)
            begin
                next_st.rd_data = sfr_rd_data; // [RULE5]
            end
            else if (st.rd_src_ram)
            begin
                next_st.rd_data = gpr_q;
            end
            else if (st.rd_src_usb)
            begin
                next_st.rd_data = usb_q;
            end
            else
            begin
                next_st.rd_data = 8'h00; // [RULE5] [RULE10]
            end
            next_st.rd_src_bsr = 1'b0;
            next_st.rd_src_sfr = 1'b0;
            next_st.rd_src_ram = 1'b0;
            next_st.rd_src_usb = 1'b0;
        end
        if (q_phase == DMB_Q4 && core_is_write && st.pend_op == DMB_OP_FILE)
        begin
            next_st.status_upd = 1'b1; // [RULE10]
        end
        if (core_q4_wr && st.addr == DMB_BANK_SEL_ADDR)
        begin
            next_st.bank = wr_data[3:0]; // [RULE7]
        end
        // move write is one-shot: a held word must not write again
        if (q_phase == DMB_Q4)
        begin
            next_st.move_wr = 1'b0;
        end
        // usb engine owns the ram in the phases the core leaves idle
        if (usb_enable && usb_req && (q_phase == DMB_Q1 || q_phase == 2'h2))
        begin
            next_st.usb_phase = 1'b1;
        end
        // ram answers on the edge after the grant
        if (st.usb_phase)
        begin
            next_st.usb_rd = usb_q;
        end
        if (srst)
        begin
            next_st = '0;
            next_st.pend_op = DMB_OP_NONE;
            next_st.bank = DMB_BANK_SEL_RESET[3:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st <= next_st;
    end

    // =====================================================
    // memories
    logic usb_slot;
    assign core_q4_wr = (q_phase == DMB_Q4)
        && ((core_is_write && st.pend_op == DMB_OP_FILE) || st.move_wr);
    // core uses q2/q4, usb engine q1/q3: no same-cycle collision
    assign usb_slot = usb_enable && usb_req
        && (q_phase == DMB_Q1 || q_phase == 2'h2); // [RULE19] [RULE6]
    assign gpr_addr = st.addr[8:0];
    assign gpr_we = core_q4_wr && in_gpr && !srst; // [RULE10] [RULE16]
    assign usbram_addr = usb_slot ? usb_addr : st.addr[7:0];
    assign usbram_wdata = usb_slot ? usb_wr_data : wr_data;
    assign usb_ram_we = usb_slot ? usb_we
        : (core_q4_wr && in_usb && !srst); // [RULE19]

    dmb_ram #(.ADDR_W(9), .DEPTH(DMB_GPR_BYTES)) u_gpr
    (
        .sys_clk(sys_clk),
        .wr_en(gpr_we),
        .addr(gpr_addr),
        .wr_data(wr_data),
        .rd_data(gpr_q)
    );

    dmb_ram #(.ADDR_W(8), .DEPTH(DMB_USB_BYTES)) u_usb
    (
        .sys_clk(sys_clk),
        .wr_en(usb_ram_we),
        .addr(usbram_addr),
        .wr_data(usbram_wdata),
        .rd_data(usb_q)
    );

    // =====================================================
    // outputs
    assign usb_gnt = usb_slot;
    assign usb_rd_data = st.usb_rd;
    assign rd_data = st.rd_data;
    assign data_addr = st.addr;
    assign literal_out = st.literal;
    assign literal_valid = st.literal_valid;
    assign sfr_addr = st.addr;
    assign sfr_wr_data = wr_data;
    assign sfr_rd = (q_phase == DMB_Q2) && in_sfr
        && (st.pend_op != DMB_OP_NONE); // [RULE17]
    assign sfr_wr = core_q4_wr && in_sfr && st.addr != DMB_BANK_SEL_ADDR;
    assign bank_select = bsr_view;
    assign status_update = st.status_upd;
endmodule // dmb_data_mem

// ---- hdl/dmb_pkg.sv ----
// package: constants for the banked data memory block
package dmb_pkg;
    localparam int DMB_ADDR_W = 12;
    localparam int DMB_OFS_W = 8;
    localparam int DMB_BANK_W = 4;
    localparam logic [3:0] DMB_WORD2_MARK = 4'hf;
    localparam logic [7:0] DMB_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] DMB_SFR_BANK = 4'hf;
    localparam logic [11:0] DMB_SFR_BASE = 12'hf60;
    localparam logic [11:0] DMB_BANK_SEL_ADDR = 12'hfe0;
    localparam logic [7:0] DMB_BANK_SEL_RESET = 8'h00;
    localparam logic [11:0] DMB_GPR_BASE = 12'h000;
    localparam int DMB_GPR_BYTES = 512;
    localparam logic [11:0] DMB_USB_BASE = 12'h200;
    localparam int DMB_USB_BYTES = 256;
    localparam logic [1:0] DMB_Q1 = 2'h0;
    localparam logic [1:0] DMB_Q2 = 2'h1;
    localparam logic [1:0] DMB_Q4 = 2'h3;
    typedef enum logic [2:0] {
        DMB_OP_NONE,
        DMB_OP_CALL,
        DMB_OP_GOTO,
        DMB_OP_FULL_MOVE,
        DMB_OP_PTR_LOAD,
        DMB_OP_BANK_LOAD,
        DMB_OP_FILE
    } dmb_op_e;
endpackage

// ---- hdl/dmb_ram.sv ----
// single-port byte memory with registered read data
`timescale 1ns/10ps
module dmb_ram
#(
    parameter int ADDR_W = 9,
    parameter int DEPTH = 512
)
(
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    if (DEPTH > (1 << ADDR_W))
    begin : g_bad_depth
        $error("depth exceeds address range");
    end

    // no reset port: contents survive every reset
    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule // dmb_ram

// ---- verification/dmb_data_mem_monitor.sv ----
// checker: port-level properties of the banked data memory
`timescale 1ns/10ps
module dmb_data_mem_monitor
import dmb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic [1:0] q_phase,
    input wire logic extended_set_enable,
    input wire logic usb_enable,
    input wire logic usb_req,
    input wire logic usb_gnt,
    input wire logic [7:0] rd_data,
    input wire logic [11:0] data_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [11:0] sfr_addr,
    input wire logic [7:0] bank_select,
    input wire logic status_update
);
// ==================================================
// decode helpers
logic take;
logic fop;
assign take = instr_valid && q_phase == DMB_Q1;
assign fop = take && instr_word[15:10] == 6'b001001 && !extended_set_enable;
default clocking cb @(posedge sys_clk); endclocking
default disable iff (srst);
// ==================================================
// properties
a_bank_upper_zero: assert property (bank_select[7:4] == 4'h0)
    else $error("bank select upper bits not zero");
a_bank_load: assert property (take && instr_word[15:8] == 8'h01
    |-> ##4 bank_select == {4'h0, $past(instr_word[3:0], 4)})
    else $error("bank select not loaded from literal");
a_banked_addr: assert property (fop && instr_word[8]
    |=> data_addr == {bank_select[3:0], $past(instr_word[7:0])})
    else $error("banked address wrong");
a_access_map: assert property (fop && !instr_word[8]
    |=> data_addr == {($past(instr_word[7:0]) < DMB_ACCESS_SPLIT) ?
    4'h0 : DMB_SFR_BANK, $past(instr_word[7:0])})
    else $error("access bank address wrong");
a_status_pulse: assert property (fop && instr_word[9]
    |-> ##4 status_update)
    else $error("status update missing after write");
a_unmapped_zero: assert property (fop && instr_word[8] &&
    bank_select[3:0] inside {[4'h3:4'he]} |-> ##3 rd_data == 8'h00)
    else $error("unimplemented bank read not zero");
a_sfr_rd_phase: assert property (sfr_rd |-> q_phase == DMB_Q2
    && sfr_addr >= DMB_SFR_BASE)
    else $error("special register read outside phase or range");
a_sfr_wr_phase: assert property (sfr_wr |-> q_phase == DMB_Q4)
    else $error("special register write outside fourth phase");
a_usb_slot: assert property (usb_gnt |-> usb_req && usb_enable
    && q_phase[0] == 1'b0)
    else $error("usb grant outside engine slot");
endmodule // dmb_data_mem_monitor

bind dmb_data_mem dmb_data_mem_monitor u_mon (.sys_clk, .srst, .instr_word,
    .instr_valid, .q_phase, .extended_set_enable, .usb_enable, .usb_req,
    .usb_gnt, .rd_data, .data_addr, .sfr_rd, .sfr_wr, .sfr_addr,
    .bank_select, .status_update);

// ---- verification/dmb_core_model.sv ----
// partner: core phase sequencer and special register stub
`timescale 1ns/10ps
module dmb_core_model
import dmb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sfr_rd,
    input wire logic [11:0] sfr_addr,
    output logic [1:0] q_phase,
    output logic [7:0] sfr_rd_data
);
// ==================================================
// sequencer and register stub
always_ff @(posedge sys_clk)
begin
    if (srst)
    begin
        q_phase <= DMB_Q1;
        sfr_rd_data <= 8'h00;
    end
    else
    begin
        q_phase <= q_phase + 2'h1;
        // toggles outside the read slot so a stale sample never matches
        sfr_rd_data <= sfr_rd ? sfr_addr[7:0] ^ 8'h5a : ~sfr_rd_data;
    end
end
endmodule // dmb_core_model

// ---- verification/tb_top.sv ----
// testbench: banked data memory against core partner and usb engine
`timescale 1ns/10ps
module tb_top;
import dmb_pkg::*;
logic sys_clk = 0;
logic srst = 1;
logic [15:0] instr_word = 16'h0000;
logic instr_valid = 0;
logic [7:0] wr_data = 8'h00;
logic usb_enable = 0;
logic usb_req = 0;
logic usb_we = 0;
logic [7:0] usb_addr = 8'h00;
logic [7:0] usb_wr_data = 8'h00;
logic [1:0] q_phase;
logic [7:0] sfr_rd_data, usb_rd_data, rd_data, bank_select, b, o, x;
logic [11:0] data_addr, literal_out, sfr_addr, g_addr, g_lit;
logic usb_gnt, literal_valid, sfr_rd, sfr_wr, status_update, g_lv, g_st;
logic [7:0] g_rd;
logic [7:0] bnd [3] = '{8'h5f, 8'h60, 8'hff};
logic [31:0] seed = 32'hdc28f8b9;
int err_total = 0;
int comparisons = 0;

dmb_core_model u_core (.sys_clk, .srst, .sfr_rd, .sfr_addr, .q_phase,
    .sfr_rd_data);
dmb_data_mem uut (.sys_clk, .srst, .instr_word, .instr_valid, .q_phase,
    .wr_data, .extended_set_enable(1'b0), .usb_enable, .sfr_rd_data,
    .usb_req, .usb_we, .usb_addr, .usb_wr_data, .usb_gnt, .usb_rd_data,
    .rd_data, .data_addr, .literal_out, .literal_valid, .sfr_rd, .sfr_wr,
    .sfr_addr, .sfr_wr_data(), .bank_select, .status_update);

initial forever #10 sys_clk = ~sys_clk;
// ==================================================
// helpers
function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
function automatic logic [15:0] fop(input logic d, a, input logic [7:0] v);
    return {6'b001001, d, a, v};
endfunction
function automatic logic [11:0] acc(input logic [7:0] v);
    return {(v < DMB_ACCESS_SPLIT) ? 4'h0 : DMB_SFR_BANK, v};
endfunction
task final_report;
    if (err_total == 0 && comparisons > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
task chk(input string n, input logic [11:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
        err_total++;
        $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
endtask
// one instruction cycle: Q1 take, Q2 address, Q4 operand, then status
task exec(input logic [15:0] w, input logic [7:0] d);
    int n;
    n = 0;
    while (q_phase !== DMB_Q1 && n < 8)
    begin
        @(posedge sys_clk);
        #1;
        n++;
    end
    if (n == 8)
    begin
        err_total++;
        final_report();
    end
    instr_word = w;
    instr_valid = 1;
    wr_data = d;
    @(posedge sys_clk);
    #1;
    instr_valid = 0;
    g_addr = data_addr;
    g_lv = literal_valid;
    g_lit = literal_out;
    repeat (2) @(posedge sys_clk);
    #1;
    g_rd = rd_data;
    @(posedge sys_clk);
    #1;
    g_st = status_update;
endtask
// engine request held until the grant edge, then released
task usb_op(input logic we, input logic [7:0] a, d);
    int n;
    n = 0;
    usb_req = 1;
    usb_we = we;
    usb_addr = a;
    usb_wr_data = d;
    // grant is combinational: let it settle before looking
    #1;
    while (usb_gnt !== 1'b1 && n < 16)
    begin
        @(posedge sys_clk);
        #1;
        n++;
    end
    if (n == 16)
    begin
        err_total++;
        final_report();
    end
    @(posedge sys_clk);
    #1;
    usb_req = 0;
    usb_addr = ~a;
    usb_wr_data = ~d;
    @(posedge sys_clk);
    #1;
    g_rd = usb_rd_data;
endtask
// ==================================================
// scenarios
initial
begin
    repeat (8) @(posedge sys_clk);
    #1;
    srst = 0;
    chk("bank_select", 12'(bank_select), 12'h000);
    exec(16'h01a3, 8'h00);
    chk("bank_select", 12'(bank_select), 12'h003);
    for (int i = 0; i < 6; i++)
    begin
        seed = lfsr(seed);
        b = 8'(i % 3);
        o = seed[7:0];
        x = seed[23:16];
        exec({8'h01, b}, 8'h00);
        exec(fop(1'b1, 1'b1, o), x);
        chk("banked_addr", g_addr, {b[3:0], o});
        exec(fop(1'b0, 1'b1, o), 8'h00);
        chk("gpr_read", 12'(g_rd), 12'(x));
    end
    exec(16'h0105, 8'h00);
    exec(fop(1'b1, 1'b1, 8'h44), 8'h77);
    chk("dropped_status", 12'(g_st), 12'h001);
    exec(fop(1'b0, 1'b1, 8'h44), 8'h00);
    chk("unmapped_read", 12'(g_rd), 12'h000);
    exec(fop(1'b1, 1'b0, 8'h10), 8'h3c);
    chk("access_low", g_addr, 12'h010);
    foreach (bnd[k])
    begin
        exec(fop(1'b0, 1'b0, bnd[k]), 8'h00);
        chk("access_addr", g_addr, acc(bnd[k]));
    end
    chk("sfr_read", 12'(g_rd), 12'(8'hff ^ 8'h5a));
    exec(fop(1'b1, 1'b0, 8'he0), 8'ha7);
    chk("bank_write", 12'(bank_select), 12'h007);
    exec(16'hef03, 8'h00);
    exec(16'hf0c3, 8'h00);
    chk("goto_literal", g_lit, 12'h0c3);
    chk("goto_pair", 12'(g_lv), 12'h001);
    exec(16'hc010, 8'h00);
    chk("move_src", 12'(g_rd), 12'h03c);
    // core forwards the source byte as write data of the second word
    exec(16'hf1a5, g_rd);
    chk("move_dst", g_addr, 12'h1a5);
    chk("move_literal", g_lit, 12'h1a5);
    chk("move_pair", 12'(g_lv), 12'h001);
    exec(16'h0101, 8'h00);
    exec(fop(1'b0, 1'b1, 8'ha5), 8'h00);
    chk("move_data", 12'(g_rd), 12'h03c);
    exec(16'hf1a5, 8'h00);
    chk("lone_word2", 12'(g_lv), 12'h000);
    usb_enable = 1;
    usb_op(1'b1, 8'h21, 8'h96);
    exec(16'h0102, 8'h00);
    exec(fop(1'b0, 1'b1, 8'h21), 8'h00);
    chk("usb_to_core", 12'(g_rd), 12'h096);
    exec(fop(1'b1, 1'b1, 8'h22), 8'h69);
    usb_op(1'b0, 8'h22, 8'h00);
    chk("core_to_usb", 12'(g_rd), 12'h069);
    final_report();
end
endmodule // tb_top
